// ===== rtl/dtc_pkg.sv
// constants and carriers of the dual timer control block
// assumes one 200 MHz clock and a classic wishbone master of 32 bits
package dtc_pkg;

    // ****************************************
    // bus shape and register map
    // ****************************************
    localparam int         DTC_AW         = 8;
    localparam int         DTC_DW         = 32;
    localparam logic [7:0] DTC_IDX_CTRL   = 8'h00;
    localparam logic [7:0] DTC_IDX_COMMON = 8'h01;
    localparam logic [7:0] DTC_ADR_CTRL   = DTC_IDX_CTRL << 2;
    localparam logic [7:0] DTC_ADR_COMMON = DTC_IDX_COMMON << 2;

    // ****************************************
    // timer8_control fields
    // ****************************************
    localparam int DTC_C_PIN     = 0;
    localparam int DTC_C_TOIE    = 1;
    localparam int DTC_C_CAPIE   = 2;
    localparam int DTC_C_PRE     = 3;
    localparam int DTC_C_TOF     = 5;
    localparam int DTC_C_ONESHOT = 6;
    localparam int DTC_C_RUN     = 7;

    // ****************************************
    // timer_common_control fields
    // ****************************************
    localparam int DTC_M_INIT16 = 0;
    localparam int DTC_M_INIT8  = 1;
    localparam int DTC_M_SUB    = 2;
    localparam int DTC_M_LOGIC  = 4;
    localparam int DTC_M_ROUTE  = 6;
    localparam int DTC_M_MODE   = 7;

    // ****************************************
    // reset values and stop recovery keep masks
    // ****************************************
    localparam logic [7:0] DTC_CTRL_RST     = 8'h00;
    localparam logic [7:0] DTC_COMMON_RST   = 8'h00;
    localparam logic [7:0] DTC_CTRL_KEEP    = 8'h3e;
    localparam logic [7:0] DTC_COMMON_KEEP  = 8'h30;

    // ****************************************
    // counts
    // ****************************************
    localparam logic [7:0] DTC_DEMOD_RELOAD = 8'hff;
    localparam logic [3:0] DTC_FILT_SHORT   = 4'h4;
    localparam logic [3:0] DTC_FILT_LONG    = 4'h8;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic
    {
        DTC_TX    = 1'b0,
        DTC_DEMOD = 1'b1
    } dtc_mode_e;

    typedef struct packed
    {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [DTC_AW-1:0] adr;
        logic [3:0]        sel;
        logic [DTC_DW-1:0] dat;
    } dtc_wb_req_s;

    typedef struct packed
    {
        logic              ack;
        logic [DTC_DW-1:0] dat;
    } dtc_wb_rsp_s;

endpackage

// ===== rtl/dtc_timer_ctrl.sv
// control and status logic of an 8-bit timer and its 16-bit partner
// assumes synchronous pins, a wishbone classic master and an outside
// 16-bit counter that reports its run state and its timeouts
//
// Notes on behaviour
// - pin bit picks port value or timer output
// - timeout interrupt enable survives stop recovery
// - capture interrupt enable survives stop recovery
// - timeout flag sticky, write one clears
// - count mode bit: repeat or single pass, single pass in transmit only
// - run bit starts, stops, reads back state
// - mode bit: transmit or demodulation
// - transmit: long counter output initial level
// - transmit: short timer output initial level
// - demodulation: falling edge flag, write one clears
// - demodulation: rising edge flag, write one clears
// - demodulation: glitch filter none, 4, 8
// - transmit: outputs combine by and/or/nor/nand
// - demodulation: edge select falling, rising, both
// - demodulation: pick first or alternate input
// - edge reloads all ones, zero sets timeout
`timescale 1ns/1ps

module dtc_timer_ctrl #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 smr_i,
    // register bus
    input  wire dtc_pkg::dtc_wb_req_s wb_req_i,
    output dtc_pkg::dtc_wb_rsp_s      wb_rsp_o,
    // short timer reload, long counter status and start
    input  wire logic [CNT_W-1:0]     short_reload_i,
    input  wire logic                 long_run_i,
    input  wire logic                 long_timeout_i,
    output logic                      long_start_o,
    // pins
    input  wire logic [1:0]           port_out_i,
    input  wire logic                 first_input_pin_i,
    input  wire logic                 alternate_input_pin_i,
    output logic                      first_output_pin_o,
    output logic                      second_output_pin_o,
    // events
    output logic                      capture_rise_o,
    output logic                      capture_fall_o,
    output logic                      timeout_irq_o,
    output logic                      capture_irq_o
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic dtc_tick(input logic [1:0] code,
                                      input logic [2:0] pre);
        case (code)
            2'b00: return 1'b1;
            2'b01: return pre[0];
            2'b10: return &pre[1:0];
            default: return &pre;
        endcase
    endfunction

    function automatic logic dtc_combine(input logic [1:0] sel,
                                         input logic       a,
                                         input logic       b);
        case (sel)
            2'b00: return a & b;
            2'b01: return a | b;
            2'b10: return ~(a | b);
            default: return ~(a & b);
        endcase
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [7:0]       ctrl_q;
    logic [7:0]       ctrl_d;
    logic [7:0]       common_q;
    logic [7:0]       common_d;
    logic             ack_q;
    logic [31:0]      rdat_q;
    logic [2:0]       pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             wait_q;
    logic             st_out_q;
    logic             st_out_d;
    logic             lc_out_q;
    logic             lc_out_d;
    logic             in_q;
    logic             filt_q;
    logic             filt_d;
    logic             fprev_q;
    logic [3:0]       fcnt_q;
    logic [3:0]       fcnt_d;
    logic             pin1_q;
    logic             pin2_q;
    logic             start_q;
    logic             rise_q;
    logic             fall_q;
    logic             to_irq_q;
    logic             cap_irq_q;

    // ****************************************
    // bus decode
    // ****************************************
    wire        bus_req    = wb_req_i.cyc & wb_req_i.stb;
    wire        hit_ctrl   = wb_req_i.adr == dtc_pkg::DTC_ADR_CTRL;
    wire        hit_common = wb_req_i.adr == dtc_pkg::DTC_ADR_COMMON;
    // writes land on the edge at which the master sees ack
    wire        wr_ok      = bus_req & ack_q & wb_req_i.we & wb_req_i.sel[0];
    wire        wr_ctrl    = wr_ok & hit_ctrl;
    wire        wr_common  = wr_ok & hit_common;
    wire [7:0]  wdat       = wb_req_i.dat[7:0];
    wire        ack_d      = bus_req & ~ack_q;
    wire [31:0] rdat_d     = hit_ctrl   ? {24'h000000, ctrl_q}   :
                             hit_common ? {24'h000000, common_q} :
                                          32'h00000000;

    // ****************************************
    // mode and field views
    // ****************************************
    wire       demod     = common_q[dtc_pkg::DTC_M_MODE] ==
                           dtc_pkg::DTC_DEMOD;
    wire [1:0] sub_f     = common_q[dtc_pkg::DTC_M_SUB +: 2];
    wire [1:0] logic_f   = common_q[dtc_pkg::DTC_M_LOGIC +: 2];
    wire       route     = common_q[dtc_pkg::DTC_M_ROUTE];
    wire       run       = ctrl_q[dtc_pkg::DTC_C_RUN];
    wire       ping_pong = ~demod & (sub_f == 2'b01);
    wire       tick      = dtc_tick(ctrl_q[dtc_pkg::DTC_C_PRE +: 2],
                                    pre_q);

    // ****************************************
    // demodulator input, filter and edges
    // ****************************************
    wire       raw_in    = route ? alternate_input_pin_i
                                 : first_input_pin_i;
    wire [3:0] filt_thr  = (sub_f == 2'b01) ? dtc_pkg::DTC_FILT_SHORT
                                            : dtc_pkg::DTC_FILT_LONG;
    wire       rise_det  = filt_q & ~fprev_q;
    wire       fall_det  = ~filt_q & fprev_q;
    // code 11 of the edge field detects nothing
    wire       rise_evt  = demod & run & rise_det &
                           (logic_f == 2'b01 || logic_f == 2'b10);
    wire       fall_evt  = demod & run & fall_det &
                           (logic_f == 2'b00 || logic_f == 2'b10);
    wire       edge_evt  = rise_evt | fall_evt;

    always_comb
    begin
        filt_d = filt_q;
        fcnt_d = fcnt_q;
        if (sub_f == 2'b00 || sub_f == 2'b11 || ~demod)
        begin
            filt_d = in_q;
            fcnt_d = 4'h0;
        end
        else if (in_q == filt_q)
        begin
            fcnt_d = 4'h0;
        end
        else if (tick)
        begin
            if (fcnt_q + 4'h1 >= filt_thr)
            begin
                filt_d = in_q;
                fcnt_d = 4'h0;
            end
            else
            begin
                fcnt_d = fcnt_q + 4'h1;
            end
        end
    end

    // ****************************************
    // short timer
    // ****************************************
    wire [CNT_W-1:0] demod_load = CNT_W'(dtc_pkg::DTC_DEMOD_RELOAD);
    wire [CNT_W-1:0] reload_val = demod ? demod_load : short_reload_i;
    wire timeout_evt  = run & tick & ~wait_q & ~edge_evt &
                        (cnt_q == '0);
    wire oneshot_done = timeout_evt & ~demod &
                        ctrl_q[dtc_pkg::DTC_C_ONESHOT];
    wire [CNT_W-1:0] cnt_step = (cnt_q == '0) ? reload_val
                                              : cnt_q - 1'b1;

    // a detected edge beats the tick: the count restarts from all ones
    assign cnt_d = !run                       ? reload_val     :
                   edge_evt                   ? demod_load     :
                   ping_pong & long_timeout_i ? short_reload_i :
                   tick & ~wait_q             ? cnt_step       :
                                                cnt_q;

    // ****************************************
    // outputs of both timers
    // ****************************************
    wire init8  = common_q[dtc_pkg::DTC_M_INIT8];
    wire init16 = common_q[dtc_pkg::DTC_M_INIT16];
    // forced levels win over the long counter's own run state
    assign st_out_d = !run                     ? init8      :
                      timeout_evt && !demod    ? ~st_out_q  :
                                                 st_out_q;
    assign lc_out_d = !demod && sub_f == 2'b10 ? 1'b0       :
                      !demod && sub_f == 2'b11 ? 1'b1       :
                      !long_run_i              ? init16     :
                      long_timeout_i           ? ~lc_out_q  :
                                                 lc_out_q;

    wire combined = dtc_combine(logic_f, st_out_q, lc_out_q);
    wire pin1_d   = ctrl_q[dtc_pkg::DTC_C_PIN] ? st_out_q
                                               : port_out_i[0];
    wire pin2_d   = (~demod & route) ? combined
                                     : port_out_i[1];

    // ****************************************
    // register next values
    // ****************************************
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d = wdat;
            ctrl_d[dtc_pkg::DTC_C_TOF] = ctrl_q[dtc_pkg::DTC_C_TOF] &
                                         ~wdat[dtc_pkg::DTC_C_TOF];
        end
        // a start written in the same cycle beats the single pass stop
        if (oneshot_done && !(wr_ctrl && wdat[dtc_pkg::DTC_C_RUN]))
        begin
            ctrl_d[dtc_pkg::DTC_C_RUN] = 1'b0;
        end
        if (timeout_evt)
        begin
            ctrl_d[dtc_pkg::DTC_C_TOF] = 1'b1;
        end
        if (smr_i)
        begin
            ctrl_d = (ctrl_d & dtc_pkg::DTC_CTRL_KEEP) |
                     (dtc_pkg::DTC_CTRL_RST &
                      ~dtc_pkg::DTC_CTRL_KEEP);
        end
    end

    // mode bit is not guarded: a change while running is left to software
    always_comb
    begin
        common_d = common_q;
        if (wr_common)
        begin
            common_d = wdat;
            if (demod)
            begin
                common_d[1:0] = common_q[1:0] & ~wdat[1:0];
            end
        end
        if (rise_evt)
        begin
            common_d[dtc_pkg::DTC_M_INIT8] = 1'b1;
        end
        if (fall_evt)
        begin
            common_d[dtc_pkg::DTC_M_INIT16] = 1'b1;
        end
        if (smr_i)
        begin
            common_d = (common_d & dtc_pkg::DTC_COMMON_KEEP) |
                       (dtc_pkg::DTC_COMMON_RST &
                        ~dtc_pkg::DTC_COMMON_KEEP);
        end
    end

    // ****************************************
    // flip-flops
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q   <= dtc_pkg::DTC_CTRL_RST;
            common_q <= dtc_pkg::DTC_COMMON_RST;
            ack_q    <= 1'b0;
            rdat_q   <= 32'h00000000;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            common_q <= common_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_q    <= 3'h0;
            cnt_q    <= '0;
            wait_q   <= 1'b0;
            st_out_q <= 1'b0;
            lc_out_q <= 1'b0;
        end
        else
        begin
            pre_q    <= pre_q + 3'h1;
            cnt_q    <= cnt_d;
            wait_q   <= ping_pong & run &
                        ((timeout_evt | wait_q) & ~long_timeout_i);
            st_out_q <= st_out_d;
            lc_out_q <= lc_out_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_q      <= 1'b0;
            filt_q    <= 1'b0;
            fprev_q   <= 1'b0;
            fcnt_q    <= 4'h0;
            pin1_q    <= 1'b0;
            pin2_q    <= 1'b0;
            start_q   <= 1'b0;
            rise_q    <= 1'b0;
            fall_q    <= 1'b0;
            to_irq_q  <= 1'b0;
            cap_irq_q <= 1'b0;
        end
        else
        begin
            in_q      <= raw_in;
            filt_q    <= filt_d;
            fprev_q   <= filt_q;
            fcnt_q    <= fcnt_d;
            pin1_q    <= pin1_d;
            pin2_q    <= pin2_d;
            start_q   <= ping_pong & timeout_evt;
            rise_q    <= rise_evt;
            fall_q    <= fall_evt;
            to_irq_q  <= ctrl_q[dtc_pkg::DTC_C_TOF] &
                         ctrl_q[dtc_pkg::DTC_C_TOIE];
            cap_irq_q <= edge_evt &
                         ctrl_q[dtc_pkg::DTC_C_CAPIE];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign wb_rsp_o.ack        = ack_q;
    assign wb_rsp_o.dat        = rdat_q;
    assign long_start_o        = start_q;
    assign first_output_pin_o  = pin1_q;
    assign second_output_pin_o = pin2_q;
    assign capture_rise_o      = rise_q;
    assign capture_fall_o      = fall_q;
    assign timeout_irq_o       = to_irq_q;
    assign capture_irq_o       = cap_irq_q;

endmodule

// ===== bench/dtc_timer_ctrl_sva.sv
// checker of the dual timer control block, ports only
// assumes one clock, sync reset and a classic wishbone master
`timescale 1ns/1ps

module dtc_timer_ctrl_sva (
    // clock and reset
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 smr_i,
    // register bus
    input wire dtc_pkg::dtc_wb_req_s wb_req_i,
    input wire dtc_pkg::dtc_wb_rsp_s wb_rsp_o,
    // pins and events
    input wire logic [1:0]           port_out_i,
    input wire logic                 long_start_o,
    input wire logic                 first_output_pin_o,
    input wire logic                 second_output_pin_o,
    input wire logic                 capture_rise_o,
    input wire logic                 capture_fall_o,
    input wire logic                 capture_irq_o
);
    // ****************************************
    // shadow of written control bits
    // ****************************************
    // run is only trusted while 0: single pass may clear it unseen
    logic wr_c;
    logic wr_m;
    logic mapped;
    logic pin_q, run_q, init8_q, route_q, mode_q;
    assign wr_c = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0]
                  && wb_req_i.adr == dtc_pkg::DTC_ADR_CTRL;
    assign wr_m = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0]
                  && wb_req_i.adr == dtc_pkg::DTC_ADR_COMMON;
    assign mapped = wb_req_i.adr == dtc_pkg::DTC_ADR_CTRL
                    || wb_req_i.adr == dtc_pkg::DTC_ADR_COMMON;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || smr_i)
            {pin_q, run_q, init8_q, route_q, mode_q} <= 5'h00;
        else if (wr_c)
            {pin_q, run_q} <= {wb_req_i.dat[0], wb_req_i.dat[7]};
        else if (wr_m)
            {init8_q, route_q, mode_q} <= {wb_req_i.dat[1],
                                           wb_req_i.dat[7:6]};
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    endsequence
    sequence s_ack;
        wb_rsp_o.ack ##1 !wb_rsp_o.ack;
    endsequence

    a_ack_next: assert property (s_req |=> s_ack)
        else $error("ack not one cycle after request");
    a_ack_cause: assert property ($rose(wb_rsp_o.ack)
        |-> $past(wb_req_i.cyc && wb_req_i.stb))
        else $error("ack without request");
    a_upper_zero: assert property (wb_rsp_o.ack && !wb_req_i.we
        |-> wb_rsp_o.dat[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_read: assert property (wb_rsp_o.ack && !mapped
        && !wb_req_i.we |-> wb_rsp_o.dat == 32'h0)
        else $error("unmapped read not zero");
    a_first_pin_port: assert property ($past(!pin_q)
        && !$past(rst_i) |-> first_output_pin_o == $past(port_out_i[0]))
        else $error("first pin not port value");
    a_second_pin_port: assert property ($past(!route_q && !mode_q)
        && !$past(rst_i) |-> second_output_pin_o == $past(port_out_i[1]))
        else $error("second pin not port value");
    a_short_init: assert property ($past(pin_q && !run_q && !mode_q)
        && $past(pin_q && !run_q && !mode_q, 2)
        && $past(init8_q) == $past(init8_q, 2)
        |-> first_output_pin_o == $past(init8_q))
        else $error("idle short output not initial level");
    a_irq_with_edge: assert property (capture_irq_o
        |-> capture_rise_o || capture_fall_o)
        else $error("capture irq without edge");
    a_edge_exclusive: assert property (
        !(capture_rise_o && capture_fall_o))
        else $error("rise and fall at once");
    a_start_pulse: assert property (long_start_o |=> !long_start_o)
        else $error("long start longer than a pulse");
endmodule

bind dtc_timer_ctrl dtc_timer_ctrl_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .smr_i(smr_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .port_out_i(port_out_i),
    .long_start_o(long_start_o), .first_output_pin_o(first_output_pin_o),
    .second_output_pin_o(second_output_pin_o),
    .capture_rise_o(capture_rise_o), .capture_fall_o(capture_fall_o),
    .capture_irq_o(capture_irq_o));

// ===== bench/dtc_pin_model.sv
// far side of the block: input pins and the outside long counter
// assumes the bench sets pin levels and the long count length
`timescale 1ns/1ps

module dtc_pin_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // commands from the bench and start from the block
    input  wire logic [1:0] lvl_i,
    input  wire logic [3:0] len_i,
    input  wire logic       start_i,
    // pins and long counter status
    output logic            first_pin_o,
    output logic            alt_pin_o,
    output logic            long_run_o,
    output logic            long_timeout_o
);
    logic [3:0] cnt_q;

    // len_i picks a prompt or a slow answer to each start
    always_ff @(posedge clk_i)
    begin
        first_pin_o    <= lvl_i[0];
        alt_pin_o      <= lvl_i[1];
        long_timeout_o <= 1'b0;
        if (rst_i)
        begin
            long_run_o <= 1'b0;
            cnt_q      <= 4'h0;
        end
        else if (start_i)
        begin
            long_run_o <= 1'b1;
            cnt_q      <= len_i;
        end
        else if (long_run_o)
        begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0)
            begin
                long_run_o     <= 1'b0;
                long_timeout_o <= 1'b1;
            end
        end
    end
endmodule

// ===== bench/dtc_timer_ctrl_tb.sv
// self-checking bench of the dual timer control block
// assumes the pin model on the far side and a 200 MHz clock
`timescale 1ns/1ps

module dual_timer_control_regs_tb;
    localparam logic [7:0] A_C = dtc_pkg::DTC_ADR_CTRL;
    localparam logic [7:0] A_M = dtc_pkg::DTC_ADR_COMMON;
    logic clk_i, rst_i, smr_i, long_run, long_to, long_start;
    logic pin_a, pin_b, out1, out2, rise, fall, to_irq, cap_irq;
    dtc_pkg::dtc_wb_req_s req;
    dtc_pkg::dtc_wb_rsp_s rsp;
    logic [7:0]  reload;
    logic [1:0]  port, lvl, m;
    logic [3:0]  len;
    logic [31:0] rnd, v, exq[$];
    int bad_count, checked, cyc_n, n_rise, n_fall, n_irq, n_start;

    dtc_timer_ctrl DUT (
        .clk_i(clk_i), .rst_i(rst_i), .smr_i(smr_i), .wb_req_i(req),
        .wb_rsp_o(rsp), .short_reload_i(reload), .long_run_i(long_run),
        .long_timeout_i(long_to), .long_start_o(long_start),
        .port_out_i(port), .first_input_pin_i(pin_a),
        .alternate_input_pin_i(pin_b), .first_output_pin_o(out1),
        .second_output_pin_o(out2), .capture_rise_o(rise),
        .capture_fall_o(fall), .timeout_irq_o(to_irq),
        .capture_irq_o(cap_irq));
    dtc_pin_model u_pins (
        .clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl), .len_i(len),
        .start_i(long_start), .first_pin_o(pin_a), .alt_pin_o(pin_b),
        .long_run_o(long_run), .long_timeout_o(long_to));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic comb(input logic [1:0] lg,
                                  input logic a, input logic b);
        case (lg)
            2'h0: comb = a & b;
            2'h1: comb = a | b;
            2'h2: comb = ~(a | b);
            default: comb = ~(a & b);
        endcase
    endfunction
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // request held until ack is sampled, then released for a cycle
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, a, s, d};
        @(posedge clk_i);
        while (rsp.ack !== 1'b1)
            @(posedge clk_i);
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exq.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic hold(input logic [1:0] l, input int n);
        @(posedge clk_i);
        lvl <= l;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // clock, timeout and result watcher
    // ****************************************
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            bad_count++;
            give_verdict();
        end
        if (rsp.ack === 1'b1 && req.we === 1'b0)
            chk("read data", exq.pop_front(), rsp.dat);
        if (rise === 1'b1) n_rise++;
        if (fall === 1'b1) n_fall++;
        if (cap_irq === 1'b1) n_irq++;
        if (long_start === 1'b1) n_start++;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst_i = 1'b1;
        smr_i = 1'b0;
        req = '0;
        reload = 8'h03;
        port = 2'b00;
        lvl = 2'b00;
        len = 4'h1;
        rnd = 32'h0e16d12e;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_C, 32'h0);
        rd(A_M, 32'h0);
        wr(8'h08, 32'hff);
        rd(8'h08, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            wr(A_C, rnd & 32'h7f);
            rd(A_C, rnd & 32'h5f);
            wr(A_M, rnd[15:8] & 32'h7f);
            rd(A_M, rnd[15:8] & 32'h7f);
        end
        bus(1'b1, A_C, ~rnd, 4'he);
        rd(A_C, rnd & 32'h5f);
        $display("test registers done");
        wr(A_C, 32'h0);
        wr(A_M, 32'h0);
        repeat (16)
        begin
            rnd = lfsr(rnd);
            port <= rnd[1:0];
            repeat (2) @(posedge clk_i);
            chk("first pin", {31'h0, rnd[0]}, {31'h0, out1});
            chk("second pin", {31'h0, rnd[1]}, {31'h0, out2});
        end
        wr(A_C, 32'h01);
        for (int i = 0; i < 32; i++)
        begin
            v = {24'h0, 2'b01, i[1:0], i[4], i[4] & i[3], i[2], i[3]};
            wr(A_M, v);
            repeat (4) @(posedge clk_i);
            chk("first pin", {31'h0, i[2]}, {31'h0, out1});
            chk("second pin", {31'h0, comb(i[1:0], i[2], i[3])},
                {31'h0, out2});
        end
        $display("test pins done");
        wr(A_C, 32'h92);
        while (to_irq !== 1'b1) @(posedge clk_i);
        rd(A_C, 32'hb2);
        wr(A_C, 32'h32);
        rd(A_C, 32'h12);
        chk("timeout irq", 32'h0, {31'h0, to_irq});
        wr(A_C, 32'hc2);
        while (to_irq !== 1'b1) @(posedge clk_i);
        rd(A_C, 32'h62);
        wr(A_C, 32'h1f);
        rd(A_C, 32'h3f);
        wr(A_M, 32'h7f);
        @(posedge clk_i);
        smr_i <= 1'b1;
        @(posedge clk_i);
        smr_i <= 1'b0;
        rd(A_C, 32'h3e);
        rd(A_M, 32'h30);
        $display("test timer done");
        wr(A_C, 32'h0);
        wr(A_M, 32'h80);
        for (int ec = 0; ec < 3; ec++)
        begin
            v = {24'h0, 1'b1, ec == 2, ec[1:0], ec[1:0], 2'b00};
            m = (ec == 2) ? 2'b10 : 2'b01;
            wr(A_C, 32'h0);
            wr(A_M, v | 32'h3);
            wr(A_C, 32'h84);
            n_rise = 0;
            n_fall = 0;
            n_irq = 0;
            hold(~m, 30);
            hold(2'b00, 30);
            hold(m, 1);
            hold(2'b00, 30);
            hold(m, 30);
            hold(2'b00, 30);
            chk("rising edges", 32'(ec != 0), n_rise);
            chk("falling edges", (ec == 0) ? 2 : ec - 1,
                n_fall);
            chk("capture irq", (ec == 1) ? 1 : 2,
                n_irq);
            rd(A_M, v | {30'h0, ec != 0, ec != 1});
            wr(A_M, v | 32'h1);
            rd(A_M, v | {30'h0, ec != 0, 1'b0});
        end
        wr(A_C, 32'h0);
        wr(A_M, 32'h0);
        $display("test demodulation done");
        reload <= 8'h02;
        n_start = 0;
        wr(A_M, 32'h04);
        wr(A_C, 32'h80);
        while (n_start < 2) @(posedge clk_i);
        len <= 4'hc;
        while (n_start < 4) @(posedge clk_i);
        wr(A_C, 32'h0);
        $display("test ping-pong done");
        give_verdict();
    end
endmodule
